// [core/smr_pkg.sv]
/*
  Constants and carriers for the region and identification register bank.
  Assumes a byte-wide indexed configuration port on one clock, mclk.
*/
// Contract
// [RULE1] Region config as three indexed byte registers
// [RULE2] Lock bit zero of control three gates writes
// [RULE3] Size code zero disables, doubling from 4K
// [RULE4] Size code all-ones equals code one
// [RULE5] Identification byte fixed, writes ignored
// [RULE6] Lock blocks writes except inside handler
// [RULE7] Lock bit sticky until processor reset
// [RULE8] Locked writes dropped silently, no error
package smr_pkg;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [7:0] SMR_IDX_REGION_A = 8'hCD;
  localparam logic [7:0] SMR_IDX_REGION_B = 8'hCE;
  localparam logic [7:0] SMR_IDX_REGION_C = 8'hCF;
  localparam logic [7:0] SMR_IDX_CTRL3    = 8'hC3;
  localparam logic [7:0] SMR_IDX_IDENT    = 8'hFE;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int         SMR_LOCK_BIT     = 0;
  localparam int         SMR_SIZE_LSB     = 0;
  localparam logic [7:0] SMR_REGION_RST   = 8'h00;
  localparam logic [7:0] SMR_CTRL3_RST    = 8'h00;
  localparam logic [7:0] SMR_READ_ZERO    = 8'h00;
  // Arbitrary neutral identification value
  localparam logic [7:0] SMR_IDENT_VALUE  = 8'h5A;
  localparam logic [3:0] SMR_SIZE_OFF     = 4'h0;
  localparam logic [3:0] SMR_SIZE_ALIAS   = 4'hF;
  localparam logic [3:0] SMR_SIZE_ONE     = 4'h1;
  localparam int         SMR_SIZE_W       = 26;
  localparam int         SMR_SIZE_BASE_SH = 12;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } smr_req_t;

  typedef struct packed {
    logic                  enabled;
    logic [SMR_SIZE_W-1:0] bytes;
  } smr_size_t;

endpackage

// [core/smr_size_dec.sv]
/*
  Decodes the 4-bit region size code into a byte count.
  Assumes the code comes from a register; purely combinational.
*/
`timescale 1ns/10ps
module smr_size_dec (
  input  wire logic [3:0]      code,
  output smr_pkg::smr_size_t   size
);

  // ************************************************************
  // Decode
  // ************************************************************
  logic [3:0] eff;

  always_comb begin
    // [RULE4] Alias all-ones code
    eff = (code == smr_pkg::SMR_SIZE_ALIAS) ? smr_pkg::SMR_SIZE_ONE : code;
    // [RULE3] Zero disables, doubling sizes
    size.enabled = (eff != smr_pkg::SMR_SIZE_OFF);
    if (eff == smr_pkg::SMR_SIZE_OFF) begin
      size.bytes = '0;
    end else begin
      size.bytes = smr_pkg::SMR_SIZE_W'(1) <<
                   (smr_pkg::SMR_SIZE_BASE_SH - 1 + int'(eff));
    end
  end

endmodule // smr_size_dec

// [core/smr_regs.sv]
/*
  Region registers, lock bit and identification byte behind an indexed
  configuration port. Assumes one strobe per cycle and a handler flag
  from the core that is high while the management handler runs.
*/
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module smr_regs (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  input  wire logic                  in_handler,
  output logic      [7:0]            rdata,
  output logic      [23:0]           region_regs,
  output logic                       config_lock,
  output logic                       region_enabled,
  output logic      [25:0]           region_bytes
);

  // ************************************************************
  // State
  // ************************************************************
  smr_pkg::smr_req_t  req;
  smr_pkg::smr_size_t size;
  logic [7:0] reg_a_reg, reg_a_next;
  logic [7:0] reg_b_reg, reg_b_next;
  logic [7:0] reg_c_reg, reg_c_next;
  logic [7:0] ctrl3_reg, ctrl3_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       may_write;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ************************************************************
  // Next values
  // ************************************************************
  always_comb begin
    reg_a_next = reg_a_reg;
    reg_b_next = reg_b_reg;
    reg_c_next = reg_c_reg;
    ctrl3_next = ctrl3_reg;
    rdata_next = smr_pkg::SMR_READ_ZERO;
    // [RULE2] Lock gates writes
    // [RULE6] Handler bypasses lock
    may_write = !ctrl3_reg[smr_pkg::SMR_LOCK_BIT] || in_handler;
    if (req.wr) begin
      // [RULE1] Three indexed bytes
      // [RULE8] Locked writes dropped
      if (req.addr == smr_pkg::SMR_IDX_REGION_A) begin
        if (may_write) reg_a_next = req.wdata;
      end else if (req.addr == smr_pkg::SMR_IDX_REGION_B) begin
        if (may_write) reg_b_next = req.wdata;
      end else if (req.addr == smr_pkg::SMR_IDX_REGION_C) begin
        if (may_write) reg_c_next = req.wdata;
      end else if (req.addr == smr_pkg::SMR_IDX_CTRL3) begin
        ctrl3_next = req.wdata;
        // [RULE7] Lock stays set
        if (ctrl3_reg[smr_pkg::SMR_LOCK_BIT]) begin
          ctrl3_next[smr_pkg::SMR_LOCK_BIT] = 1'b1;
        end
      end
      // [RULE5] Ident writes ignored
    end
    if (req.rd) begin
      if (req.addr == smr_pkg::SMR_IDX_REGION_A) begin
        rdata_next = reg_a_reg;
      end else if (req.addr == smr_pkg::SMR_IDX_REGION_B) begin
        rdata_next = reg_b_reg;
      end else if (req.addr == smr_pkg::SMR_IDX_REGION_C) begin
        rdata_next = reg_c_reg;
      end else if (req.addr == smr_pkg::SMR_IDX_CTRL3) begin
        rdata_next = ctrl3_reg;
      end else if (req.addr == smr_pkg::SMR_IDX_IDENT) begin
        // [RULE5] Fixed ident value
        rdata_next = smr_pkg::SMR_IDENT_VALUE;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Only the reset clears the lock, so reset gives the sole way out
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_a_reg <= smr_pkg::SMR_REGION_RST;
      reg_b_reg <= smr_pkg::SMR_REGION_RST;
      reg_c_reg <= smr_pkg::SMR_REGION_RST;
      ctrl3_reg <= smr_pkg::SMR_CTRL3_RST;
      rdata_reg <= smr_pkg::SMR_READ_ZERO;
    end else begin
      reg_a_reg <= reg_a_next;
      reg_b_reg <= reg_b_next;
      reg_c_reg <= reg_c_next;
      ctrl3_reg <= ctrl3_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Size decode and outputs
  // ************************************************************
  // Size code sits in the low nibble of the last byte
  smr_size_dec u_size (
    .code (reg_c_reg[smr_pkg::SMR_SIZE_LSB +: 4]),
    .size (size)
  );

  assign rdata          = rdata_reg;
  assign region_regs    = {reg_c_reg, reg_b_reg, reg_a_reg};
  assign config_lock    = ctrl3_reg[smr_pkg::SMR_LOCK_BIT];
  assign region_enabled = size.enabled;
  assign region_bytes   = size.bytes;

endmodule // smr_regs

// [test/smr_regs_properties.sv]
/* Port checker for smr_regs.
   Assumes the bank's own mclk and rstn. */
`timescale 1ns/10ps
module smr_regs_properties (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        in_handler,
  input wire logic [7:0]  rdata,
  input wire logic [23:0] region_regs,
  input wire logic        config_lock,
  input wire logic        region_enabled,
  input wire logic [25:0] region_bytes
);
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic [3:0] code = region_regs[19:16];
  a_write_open: assert property (wr && addr == 8'hCD &&
    (!config_lock || in_handler) |=> region_regs[7:0] == $past(wdata))
    else $error("open write lost");
  a_lock_hold: assert property (wr && !in_handler && config_lock &&
    addr inside {8'hCD, 8'hCE, 8'hCF} |=> $stable(region_regs))
    else $error("locked write took");
  a_lock_set: assert property (wr && addr == 8'hC3 && wdata[0]
    |=> config_lock) else $error("lock not set");
  a_lock_sticky: assert property (config_lock |=> config_lock)
    else $error("lock cleared");
  a_size_off: assert property (code == 4'h0 |-> !region_enabled &&
    region_bytes == 26'h0) else $error("size zero wrong");
  a_size_pow: assert property (code inside {[4'h1:4'hE]} |->
    region_bytes == 26'h1000 << (code - 4'h1)) else $error("size wrong");
  a_size_alias: assert property (code == 4'hF |-> region_enabled &&
    region_bytes == 26'h1000) else $error("alias wrong");
  a_ident_read: assert property (rd && addr == 8'hFE |=>
    rdata == smr_pkg::SMR_IDENT_VALUE) else $error("ident wrong");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
endmodule // smr_regs_properties
bind smr_regs smr_regs_properties u_props (.mclk, .rstn, .addr, .wdata,
  .wr, .rd, .in_handler, .rdata, .region_regs, .config_lock,
  .region_enabled, .region_bytes);

// [test/smr_regs_tb_top.sv]
/* Self-checking bench for smr_regs.
   Assumes the bound checker; drives the port itself. */
`timescale 1ns/10ps
module smr_regs_tb_top;
  logic mclk, rstn, in_handler, config_lock, region_enabled;
  smr_pkg::smr_req_t req;
  logic [7:0] rdata, rv, m[3];
  logic [7:0] ix[4] = '{8'hCD, 8'hCE, 8'hCF, 8'hC3};
  logic [23:0] region_regs;
  logic [25:0] region_bytes;
  logic [31:0] lfsr = 32'h17ACA;
  int miscompares, samples_checked, cyc, k;
  smr_regs DUT (.mclk, .rstn, .addr(req.addr), .wdata(req.wdata),
    .wr(req.wr), .rd(req.rd), .in_handler, .rdata, .region_regs,
    .config_lock, .region_enabled, .region_bytes);
  function logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [25:0] eb(logic [3:0] c);
    return (c == 4'h0) ? 26'h0 : 26'h1000 << ((c == 4'hF) ? 4'h0 : c - 4'h1);
  endfunction
  task chk(string n, logic [25:0] e, logic [25:0] g);
    samples_checked++;
    if (e !== g) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task end_sim;
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One strobe cycle, then idle; read data land one edge later
  task bus(logic [7:0] a, logic [7:0] d, logic w);
    @(posedge mclk) req <= '{a, d, w, !w};
    @(posedge mclk) req <= '0;
    #1 rv = rdata;
  endtask
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      end_sim;
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    rstn = 0;
    in_handler = 0;
    req = '0;
    m = '{default: 8'h00};
    repeat (8) @(posedge mclk);
    rstn <= 1;
    foreach (ix[i]) begin
      bus(ix[i], 8'h00, 0);
      chk("reset value", 0, rv);
    end
    repeat (24) begin
      lfsr = nx(lfsr);
      k = lfsr[9:8] % 3;
      m[k] = lfsr[7:0];
      bus(ix[k], m[k], 1);
      bus(ix[k], 8'h00, 0);
      chk("region byte", m[k], rv);
    end
    chk("size bytes", eb(m[2][3:0]), region_bytes);
    for (int c = 0; c < 16; c++) begin
      bus(8'hCF, {lfsr[7:4], c[3:0]}, 1);
      chk("size code", eb(c[3:0]), region_bytes);
      chk("enabled", c != 0, region_enabled);
    end
    bus(8'hFE, lfsr[7:0], 1);
    bus(8'hFE, 8'h00, 0);
    chk("ident", smr_pkg::SMR_IDENT_VALUE, rv);
    bus(8'h10, 8'h00, 0);
    chk("unmapped", 0, rv);
    bus(8'hCD, 8'h3C, 1);
    bus(8'hC3, 8'h01, 1);
    chk("lock set", 1, config_lock);
    bus(8'hCD, 8'hA5, 1);
    bus(8'hCD, 8'h00, 0);
    chk("locked write", 8'h3C, rv);
    @(posedge mclk) in_handler <= 1;
    bus(8'hCD, 8'hA5, 1);
    bus(8'hC3, 8'h00, 1);
    bus(8'hCD, 8'h00, 0);
    chk("handler write", 8'hA5, rv);
    chk("lock sticky", 1, config_lock);
    @(posedge mclk) rstn <= 0;
    @(posedge mclk) rstn <= 1;
    #1 chk("lock reset", 0, config_lock);
    end_sim;
  end
endmodule // smr_regs_tb_top
